// ---- abs_area3_sva.sv ----
// abs_area3_sva.sv: port checks for the area 3 timing block.
// assumes ce_in high throughout.
`timescale 1ns/100ps
`default_nettype none

module abs_area3_sva #(parameter ADDR_W = 4) (
	input wire logic              sys_clk_in, rst_in, reg_wr_in, reg_rd_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0]       reg_wdata_in, reg_rdata_out,
	input wire logic              sram_mode_in, acc_req_in, acc_busy_out, acc_done_out,
	input wire logic              area_select_n_out, rd_wr_n_out, rd_n_out, wait_n_in,
	input wire logic [3:0]        byte_lane_enable_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic [5:0] cw; // select, wait code, mask

	// shadow of the writable control fields
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cw <= 6'h14;
		end else if (reg_wr_in && reg_addr_in == 0) begin
			cw <= {reg_wdata_in[20], reg_wdata_in[10:7], reg_wdata_in[6]};
		end
	end
	sequence acc_go;
		acc_req_in && !acc_busy_out;
	endsequence

	rsv_zero_a: assert property (reg_rd_in |=> reg_rdata_out[31:21] == 0 &&
		reg_rdata_out[19:11] == 0 && reg_rdata_out[5:0] == 0) else $error("reserved bits set");
	sel_cause_a: assert property ($fell(area_select_n_out) |-> $past(acc_req_in))
		else $error("select without request");
	min_len_a: assert property (acc_go |-> ##1 (!acc_done_out) [*3])
		else $error("access too short");
	rd_in_sel_a: assert property (!rd_n_out |-> !area_select_n_out)
		else $error("read strobe outside select");
	lane_sel_a: assert property (byte_lane_enable_n_out != 4'hf |-> !area_select_n_out)
		else $error("lanes outside select");
	wr_role_a: assert property ($fell(rd_wr_n_out) |->
		(byte_lane_enable_n_out == 4'hf) == !(cw[5] && sram_mode_in)) else $error("lane role");
	mask_len_a: assert property (acc_go and (cw[4:1] == 0 && cw[0]) |-> ##4 acc_done_out)
		else $error("masked wait stretched access");
	wait_ext_a: assert property ((!wait_n_in) [*4] ##0 (acc_go and (cw[4:0] == 0))
		|-> ##1 (!acc_done_out) [*4]) else $error("wait not honoured");
endmodule // abs_area3_sva

`default_nettype wire

// ---- abs_area3_timing.v ----
// abs_area3_timing.v: area 3 timing control for a byte-selection static
// memory: control word, access sequencer and memory strobe pins.
// assumes a single-cycle register port master and one access request at
// a time, given only while the block is not busy.
`timescale 1ns/100ps
`default_nettype none
`include "abs_map.vh"

// Functional notes
// - reserved control word bits read as zero
// - byte select matters only in byte-SRAM mode
// - select clear: lanes strobe, write line status
// - select set: lanes status, write line strobe
// - read wait code maps to listed cycle counts
// - reset: wait code 1010, select, mask zero
// - mask clear honours wait pin, set ignores
// - mask applies even with zero wait count
module abs_area3_timing #(
	parameter ADDR_W = 4
) (
	// clock, reset, clock enable
	input  wire              sys_clk_in,
	input  wire              rst_in,
	input  wire              ce_in,
	// register port
	input  wire [ADDR_W-1:0] reg_addr_in,
	input  wire [31:0]       reg_wdata_in,
	input  wire              reg_wr_in,
	input  wire              reg_rd_in,
	output reg  [31:0]       reg_rdata_out,
	// access requests from the bus side
	input  wire              sram_mode_in,
	input  wire              acc_req_in,
	input  wire              acc_write_in,
	input  wire [3:0]        acc_lanes_in,
	output wire              acc_busy_out,
	output reg               acc_done_out,
	// memory pins
	output reg               area_select_n_out,
	output reg  [3:0]        byte_lane_enable_n_out,
	output reg               rd_wr_n_out,
	output reg               rd_n_out,
	input  wire              wait_n_in
);

	// sequencer states
	localparam ST_IDLE  = 2'b00;
	localparam ST_SETUP = 2'b01;
	localparam ST_STRB  = 2'b10;
	localparam ST_HOLD  = 2'b11;

	reg        byte_access_select;   // lane/write line role select
	reg  [3:0] read_wait_count;      // wait code field
	reg        external_wait_mask;   // 1 ignores the wait pin
	reg  [1:0] state;                // sequencer state
	reg  [1:0] next_state;           // sequencer next state
	reg  [4:0] cnt;                  // phase cycle counter
	reg  [4:0] next_cnt;             // next counter value
	reg        acc_write;            // latched direction
	reg  [3:0] acc_lanes;            // latched lane mask
	wire       wait_level_n;         // filtered wait pin, low = wait
	wire       sel_eff;              // byte select as applied
	wire       is_write;             // direction for the next cycle
	wire [3:0] lanes;                // lanes for the next cycle

	////////////////////////////////////////////////////////////////////////
	// wait code to cycle count
	function [4:0] abs_wait_cycles;
		input [3:0] code;
		begin
			case (code)
				4'h7:    abs_wait_cycles = 5'h08;
				4'h8:    abs_wait_cycles = 5'h0a;
				4'h9:    abs_wait_cycles = 5'h0c;
				4'ha:    abs_wait_cycles = 5'h0e;
				4'hb:    abs_wait_cycles = 5'h12;
				4'hc:    abs_wait_cycles = 5'h18;
				default: abs_wait_cycles = {1'b0, code}; // 0..6; 13..15 never written
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// wait pin synchroniser
	abs_wait_sync u_wait_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.pin_in     (wait_n_in),
		.level_out  (wait_level_n)
	);

	////////////////////////////////////////////////////////////////////////
	// control word writes and read data
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			byte_access_select <= `ABS_RST_BYTE_SEL;
			read_wait_count    <= `ABS_RST_WAIT;
			external_wait_mask <= `ABS_RST_MASK;
			reg_rdata_out      <= 32'h00000000;
		end else if (ce_in) begin
			// reserved bits of the write are dropped
			if (reg_wr_in && reg_addr_in == `ABS_OFF_WAIT_CTRL) begin
				byte_access_select <= reg_wdata_in[`ABS_BIT_BYTE_SEL];
				read_wait_count    <= reg_wdata_in[`ABS_WAIT_HI:`ABS_WAIT_LO];
				external_wait_mask <= reg_wdata_in[`ABS_BIT_MASK];
			end
			// read data for one cycle, zero elsewhere
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in && reg_addr_in == `ABS_OFF_WAIT_CTRL) begin
				reg_rdata_out[`ABS_BIT_BYTE_SEL]        <= byte_access_select;
				reg_rdata_out[`ABS_WAIT_HI:`ABS_WAIT_LO] <= read_wait_count;
				reg_rdata_out[`ABS_BIT_MASK]            <= external_wait_mask;
				// all other bits stay zero
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always @* begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_IDLE: begin
				if (acc_req_in) begin
					next_state = ST_SETUP;
					next_cnt   = `ABS_SETUP_CYC - 5'h01;
				end
			end
			ST_SETUP: begin
				if (cnt == 5'h00) begin
					next_state = ST_STRB;
					next_cnt   = abs_wait_cycles(read_wait_count);
				end else begin
					next_cnt = cnt - 5'h01;
				end
			end
			ST_STRB: begin
				if (cnt != 5'h00) begin
					next_cnt = cnt - 5'h01;
				end else if (!external_wait_mask && !wait_level_n) begin
					// stretch while wait asserted, also at zero count
					next_cnt = 5'h00;
				end else begin
					next_state = ST_HOLD;
					next_cnt   = `ABS_HOLD_CYC - 5'h01;
				end
			end
			ST_HOLD: begin
				if (cnt == 5'h00) begin
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt - 5'h01;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt   = 5'h00;
			end
		endcase
	end

	// byte select applies only with the byte-selection interface
	assign sel_eff      = byte_access_select & sram_mode_in;
	assign is_write     = (state == ST_IDLE) ? acc_write_in : acc_write;
	assign lanes        = (state == ST_IDLE) ? acc_lanes_in : acc_lanes;
	assign acc_busy_out = (state != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// state, latched request and registered pins
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state                  <= ST_IDLE;
			cnt                    <= 5'h00;
			acc_write              <= 1'b0;
			acc_lanes              <= 4'h0;
			acc_done_out           <= 1'b0;
			area_select_n_out      <= 1'b1;
			byte_lane_enable_n_out <= 4'hf;
			rd_wr_n_out            <= 1'b1;
			rd_n_out               <= 1'b1;
		end else if (ce_in) begin
			state        <= next_state;
			cnt          <= next_cnt;
			acc_done_out <= (state == ST_HOLD) && (next_state == ST_IDLE);
			if (state == ST_IDLE && acc_req_in) begin
				acc_write <= acc_write_in;
				acc_lanes <= acc_lanes_in;
			end
			// select asserted through the whole access
			area_select_n_out <= (next_state == ST_IDLE);
			// read strobe only in the strobe phase of reads
			rd_n_out <= !(next_state == ST_STRB && !is_write);
			if (next_state == ST_IDLE) begin
				byte_lane_enable_n_out <= 4'hf;
				rd_wr_n_out            <= 1'b1;
			end else if (!sel_eff) begin
				// lanes pulse as strobe, write line held as status
				byte_lane_enable_n_out <= (next_state == ST_STRB) ? ~lanes : 4'hf;
				rd_wr_n_out            <= !is_write;
			end else begin
				// lanes held as status, write line pulses as strobe
				byte_lane_enable_n_out <= ~lanes;
				rd_wr_n_out            <= !(is_write && next_state == ST_STRB);
			end
		end
	end

endmodule // abs_area3_timing
`default_nettype wire

// ---- abs_area3_timing_test.sv ----
// abs_area3_timing_test.sv: self-checking bench for the area 3 timing block.
// assumes the design and memory model files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module abs_area3_timing_test;
	logic        sys_clk_in = 0, rst_in = 1, ce_in = 1, reg_wr_in = 0, reg_rd_in = 0, arm = 0;
	logic        sram_mode_in = 1, acc_req_in = 0, acc_write_in = 0, wait_n_in;
	logic        acc_busy_out, acc_done_out, area_select_n_out, rd_wr_n_out, rd_n_out;
	logic [3:0]  reg_addr_in = 0, acc_lanes_in = 4'h3, byte_lane_enable_n_out;
	logic [31:0] reg_wdata_in = 0, reg_rdata_out;
	logic [4:0]  stall = 0;
	logic [13:0] pins; // {cs, lanes, rd_wr, rd} in setup, then in first strobe cycle
	// pins per {select, write}: lanes/write line roles at setup and strobe
	logic [13:0] exp_p [4] = '{14'h1fb2, 14'h1eb1, 14'h19b2, 14'h19b1};
	int          bad_count = 0, checked = 0, n;
	int          exp_n [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24}; // waits per code

	always #25 sys_clk_in = ~sys_clk_in;
	abs_area3_timing dut (.sys_clk_in, .rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .sram_mode_in, .acc_req_in, .acc_write_in, .acc_lanes_in,
		.acc_busy_out, .acc_done_out, .area_select_n_out, .byte_lane_enable_n_out,
		.rd_wr_n_out, .rd_n_out, .wait_n_in);
	abs_sram_model mem (.sys_clk_in, .area_select_n_in(area_select_n_out), .arm_in(arm),
		.stall_in(stall), .wait_n_out(wait_n_in));

	task test_done;
		$display("mismatches %0d of %0d checks", bad_count, checked);
		if (bad_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_in) begin reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1; end
		@(posedge sys_clk_in) reg_wr_in <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk_in) begin reg_addr_in <= a; reg_rd_in <= 1; end
		@(posedge sys_clk_in) reg_rd_in <= 0;
		#1 chk(reg_rdata_out, e);
	endtask
	// one access; n ends as the cycle count from request to done
	task acc(input logic w);
		@(posedge sys_clk_in) begin acc_req_in <= 1; acc_write_in <= w; end
		@(posedge sys_clk_in) acc_req_in <= 0;
		for (n = 1; n < 100; n++) begin
			#1;
			if (n < 3) pins[7*(2-n) +: 7] = {area_select_n_out, byte_lane_enable_n_out,
				rd_wr_n_out, rd_n_out};
			if (acc_done_out === 1'b1) break;
			@(posedge sys_clk_in);
		end
		if (n == 100) begin bad_count++; test_done; end
	endtask
	task stall_for(input logic [4:0] s);
		@(posedge sys_clk_in) begin stall <= s; arm <= 1; end
		repeat (5) @(posedge sys_clk_in) arm <= 0;
	endtask

	initial begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 0;
		rd(4'h0, 32'h0000_0500);
		wr(4'h0, 32'h0010_0640);
		rd(4'h0, 32'h0010_0640);
		rd(4'h5, 32'h0);
		for (int c = 0; c < 13; c++) begin
			wr(4'h0, {11'h0, c[1], 9'h0, c[3:0], 7'h40});
			acc(c[0]);
			chk(n, exp_n[c] + 4);
			chk(pins, exp_p[c[1:0]]);
		end
		wr(4'h0, 32'h0);
		stall_for(5'h08);
		acc(0);
		chk(n > 4, 1);
		wr(4'h0, 32'h40);
		stall_for(5'h08);
		acc(0);
		chk(n, 4);
		stall_for(5'h00);
		@(posedge sys_clk_in) sram_mode_in <= 0;
		wr(4'h0, 32'h0010_0040);
		acc(1);
		chk(n, 4);
		chk(pins, 14'h1eb1);
		test_done;
	end
endmodule // abs_area3_timing_test

bind abs_area3_timing abs_area3_sva #(.ADDR_W(ADDR_W)) chk_u (.sys_clk_in, .rst_in,
	.reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .sram_mode_in,
	.acc_req_in, .acc_busy_out, .acc_done_out, .area_select_n_out, .rd_wr_n_out, .rd_n_out,
	.wait_n_in, .byte_lane_enable_n_out);

`default_nettype wire

// ---- abs_map.vh ----
// abs_map.vh: offsets, field positions, reset values and timing counts
// for the area 3 byte-selection memory timing block.
// assumes inclusion by bare name from the design files of this block.
`ifndef ABS_MAP_VH
`define ABS_MAP_VH

// register offset of the area control word
`define ABS_OFF_WAIT_CTRL   4'h0
// field positions inside the control word
`define ABS_BIT_BYTE_SEL    20
`define ABS_WAIT_HI         10
`define ABS_WAIT_LO         7
`define ABS_BIT_MASK        6
// reset values of the writable fields
`define ABS_RST_BYTE_SEL    1'b0
`define ABS_RST_WAIT        4'ha
`define ABS_RST_MASK        1'b0
// fixed phase lengths in bus clock cycles
`define ABS_SETUP_CYC       5'h01
`define ABS_HOLD_CYC        5'h01

`endif

// ---- abs_sram_model.sv ----
// abs_sram_model.sv: byte-selection memory stand-in that stretches accesses.
// assumes the bench arms a stall count before an access.
`timescale 1ns/100ps
`default_nettype none

module abs_sram_model (
	// clock and selection
	input  wire logic       sys_clk_in,
	input  wire logic       area_select_n_in,
	// stall request from the bench
	input  wire logic       arm_in,
	input  wire logic [4:0] stall_in,
	// wait line
	output wire logic       wait_n_out
);
	logic [4:0] left = 5'h00; // selected cycles still owed

	// the wait line stays low until the owed selected cycles are spent
	always @(posedge sys_clk_in) begin
		if (arm_in) begin
			left <= stall_in;
		end else if (!area_select_n_in && left != 5'h00) begin
			left <= left - 5'h01;
		end
	end
	assign wait_n_out = (left == 5'h00);
endmodule // abs_sram_model

`default_nettype wire

// ---- abs_wait_sync.v ----
// abs_wait_sync.v: three-stage synchroniser with agreement filter for the
// external wait pin.
// assumes an asynchronous pin and the block clock with its clock enable.
`timescale 1ns/100ps
`default_nettype none

module abs_wait_sync (
	// clock and reset
	input  wire sys_clk_in,
	input  wire rst_in,
	input  wire ce_in,
	// pin in, filtered level out
	input  wire pin_in,
	output reg  level_out
);

	reg s1;   // first stage, read only by s2
	reg s2;   // second stage
	reg s3;   // third stage

	////////////////////////////////////////////////////////////////////////
	// shift chain, level taken when stages two and three agree
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1        <= 1'b1;
			s2        <= 1'b1;
			s3        <= 1'b1;
			level_out <= 1'b1;
		end else if (ce_in) begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level_out <= s3;
			end
		end
	end

endmodule // abs_wait_sync
`default_nettype wire
